// ==== hw/monitor_ctrl_pkg.sv ====
package monitor_ctrl_pkg;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam logic [7:0] CTRL_OFFSET  = 8'h40;
   localparam logic [7:0] CTRL_RESET   = 8'h04;
   localparam logic [7:0] READ_IDLE    = 8'h00;
   localparam int         START_BIT    = 0;
   localparam int         LOCK_BIT     = 1;
   localparam int         READY_BIT    = 2;
   localparam int         OVERRIDE_BIT = 3;
   localparam int         VBAT_BIT     = 4;
   localparam int         RSVD_LSB     = 5;
   localparam int         RSVD_MSB     = 7;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 10;
   localparam int STARTUP_TIME_US = 1000;
   // Least time, so rounded up to whole cycles
   localparam int STARTUP_CYCLES  =
      (STARTUP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Software pause after clearing start, one slow fan clock
   localparam int FAN_SETTLE_NS     = 12500;
   localparam int FAN_SETTLE_CYCLES =
      (FAN_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ------------------------------------------------------------------
   // Monitoring start-up states
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_WARMUP = 3'b010,
      ST_VALID  = 3'b100
   } mon_state_t;

endpackage : monitor_ctrl_pkg

// ==== hw/monitor_start_lock_control.sv ====
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps

// Summary of operation
// - Start bit one runs monitoring and PWM control from programmed limits.
// - No monitoring register updates happen before start is set.
// - Start zero selects built-in default limits, ignoring programmed ones.
// - Toggling start leaves limit and parameter registers untouched.
// - Start zero drives every fan PWM at full duty.
// - Lock set makes limit and parameter registers read-only until power-off.
// - Lock set ignores lock and start writes; writing zero never clears lock.
// - Rising main power good clears the lock bit.
// - Ready bit is read-only and always reads one.
// - Override bit one forces full PWM duty regardless of lock.
// - Writing one requests a battery measurement; zero ignored; lock irrelevant.
// - Battery request clears on standby reset or battery reading update.
// - Readings are invalid during a start-up interval; flag shows validity.
// - Start zero means no temperature monitoring and readings invalid.
// - Status bits may be set only while start is one.
// - Duty registers read full scale unless start and manual mode apply.
module monitor_start_lock_control #(
   parameter int STARTUP_CYCLES = monitor_ctrl_pkg::STARTUP_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       main_power_good,
   input  wire logic       standby_power_on_reset,
   input  wire logic       vbat_updated,
   input  wire logic       manual_mode,
   output logic            monitor_run,
   output logic            limits_writable,
   output logic            pwm_full_duty,
   output logic            duty_read_full,
   output logic            vbat_request,
   output logic            status_set_en,
   output logic            readings_valid_flag
);
   import monitor_ctrl_pkg::*;

   localparam int CNT_W = $clog2(STARTUP_CYCLES + 1);

   // ------------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------------
   function automatic logic ctrl_hit(input logic [7:0] addr, input logic strobe);
      return strobe && (addr == CTRL_OFFSET);
   endfunction : ctrl_hit

   logic             wr_hit;
   logic             rd_hit;
   logic             pg_rise;
   logic             start_q,      start_d;
   logic             lock_q,       lock_d;
   logic             override_q,   override_d;
   logic             vbat_q,       vbat_d;
   logic             pg_q;
   logic [7:0]       rdata_q,      rdata_d;
   mon_state_t       state_q,      state_d;
   logic [CNT_W-1:0] cnt_q,        cnt_d;
   logic             run_q,        writable_q, full_q, duty_full_q;
   logic             status_q,     valid_q;

   assign wr_hit  = ctrl_hit(reg_addr, reg_wr);
   assign rd_hit  = ctrl_hit(reg_addr, reg_rd);
   assign pg_rise = main_power_good && !pg_q;

   // ------------------------------------------------------------------
   // Control bits
   // ------------------------------------------------------------------
   always_comb begin
      start_d    = start_q;
      lock_d     = lock_q;
      override_d = override_q;
      vbat_d     = vbat_q;
      if (pg_rise) begin
         lock_d = 1'b0;
      end
      if (vbat_updated || standby_power_on_reset) begin
         vbat_d = 1'b0;
      end
      if (wr_hit) begin
         // Reserved bits are simply not stored
         if (!lock_q) begin
            start_d = reg_wdata[START_BIT];
            if (reg_wdata[LOCK_BIT]) begin
               lock_d = 1'b1;
            end
         end
         override_d = reg_wdata[OVERRIDE_BIT];
         // Standby reset wins; a plain update loses to a fresh request
         if (reg_wdata[VBAT_BIT] && !standby_power_on_reset) begin
            vbat_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         start_q    <= CTRL_RESET[START_BIT];
         lock_q     <= CTRL_RESET[LOCK_BIT];
         override_q <= CTRL_RESET[OVERRIDE_BIT];
         vbat_q     <= CTRL_RESET[VBAT_BIT];
         pg_q       <= 1'b0;
      end else begin
         start_q    <= start_d;
         lock_q     <= lock_d;
         override_q <= override_d;
         vbat_q     <= vbat_d;
         pg_q       <= main_power_good;
      end
   end

   // ------------------------------------------------------------------
   // Start-up interval
   // ------------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         ST_IDLE: begin
            if (start_d) begin
               state_d = ST_WARMUP;
               cnt_d   = CNT_W'(STARTUP_CYCLES - 1);
            end
         end
         ST_WARMUP: begin
            if (!start_d) begin
               state_d = ST_IDLE;
            end else if (cnt_q == '0) begin
               state_d = ST_VALID;
            end else begin
               cnt_d = cnt_q - CNT_W'(1);
            end
         end
         ST_VALID: begin
            if (!start_d) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // ------------------------------------------------------------------
   // Read port and registered outputs
   // ------------------------------------------------------------------
   always_comb begin
      rdata_d = READ_IDLE;
      if (rd_hit) begin
         rdata_d[START_BIT]    = start_q;
         rdata_d[LOCK_BIT]     = lock_q;
         rdata_d[READY_BIT]    = CTRL_RESET[READY_BIT];
         rdata_d[OVERRIDE_BIT] = override_q;
         rdata_d[VBAT_BIT]     = vbat_q;
         // Upper bits stay zero from the default above
      end
   end

   // Outputs follow next state so they move on the same edge as the bits
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_q     <= READ_IDLE;
         run_q       <= 1'b0;
         writable_q  <= 1'b1;
         full_q      <= 1'b1;
         duty_full_q <= 1'b1;
         status_q    <= 1'b0;
         valid_q     <= 1'b0;
      end else begin
         rdata_q     <= rdata_d;
         run_q       <= start_d;
         writable_q  <= !lock_d;
         full_q      <= !start_d || override_d;
         duty_full_q <= !start_d || !manual_mode;
         status_q    <= start_d;
         valid_q     <= (state_d == ST_VALID);
      end
   end

   assign reg_rdata           = rdata_q;
   assign monitor_run         = run_q;
   assign limits_writable     = writable_q;
   assign pwm_full_duty       = full_q;
   assign duty_read_full      = duty_full_q;
   assign vbat_request        = vbat_q;
   assign status_set_en       = status_q;
   assign readings_valid_flag = valid_q;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Cycles since start came up, saturating so it never wraps back
   logic [CNT_W-1:0] age_q,        age_d;

   always_comb begin
      age_d = age_q;
      if (!start_q) begin
         age_d = '0;
      end else if (age_q < CNT_W'(STARTUP_CYCLES)) begin
         age_d = age_q + CNT_W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         age_q <= '0;
      end else begin
         age_q <= age_d;
      end
   end

   sequence s_start_write;
      wr_hit && !lock_q && reg_wdata[START_BIT];
   endsequence

   sequence s_start_rise;
      $rose(start_q);
   endsequence

   sequence s_locked_write;
      lock_q && wr_hit && !pg_rise;
   endsequence

   sequence s_lock_write;
      wr_hit && reg_wdata[LOCK_BIT] && !(lock_q && pg_rise);
   endsequence

   sequence s_stop_write;
      wr_hit && !lock_q && !reg_wdata[START_BIT];
   endsequence

   sequence s_warm_done;
      start_q && age_q == CNT_W'(STARTUP_CYCLES);
   endsequence

   chk_start_run: assert property (s_start_write |=> run_q && start_q)
      else $error("start write did not enable monitoring");

   chk_idle_full: assert property (!start_q |-> full_q && !run_q)
      else $error("idle start without full duty");

   chk_lock_hold: assert property (lock_q && !pg_rise |=> lock_q && !writable_q)
      else $error("lock dropped without power good");

   chk_lock_freeze: assert property (s_locked_write |=> $stable(start_q))
      else $error("start changed while locked");

   chk_lock_clear: assert property (
      pg_rise && !(wr_hit && reg_wdata[LOCK_BIT] && !lock_q) |=> !lock_q)
      else $error("power good rise did not clear lock");

   chk_ready_read: assert property (
      rd_hit |=> rdata_q[READY_BIT] && rdata_q[RSVD_MSB:RSVD_LSB] == '0)
      else $error("ready or reserved bits wrong on read");

   chk_override_full: assert property (wr_hit && reg_wdata[OVERRIDE_BIT] |=> full_q)
      else $error("override did not force full duty");

   chk_vbat_set: assert property (
      wr_hit && reg_wdata[VBAT_BIT] && !standby_power_on_reset |=> vbat_q)
      else $error("battery request not set");

   chk_vbat_clear: assert property (
      (vbat_updated || standby_power_on_reset) && !(wr_hit && reg_wdata[VBAT_BIT]) |=> !vbat_q)
      else $error("battery request not cleared");

   chk_warmup_invalid: assert property (s_start_rise |-> !valid_q ##1 !valid_q)
      else $error("readings valid too early after start");

   chk_no_status: assert property (!start_q |-> !status_q && !valid_q)
      else $error("status enabled while stopped");

   chk_duty_full: assert property (!run_q |-> duty_full_q)
      else $error("duty readback not full while stopped");

   chk_valid_early: assert property (
      start_q && age_q < CNT_W'(STARTUP_CYCLES) |-> !valid_q)
      else $error("readings valid before start-up interval ended");

   chk_valid_rise: assert property (s_warm_done |-> valid_q)
      else $error("readings not valid after start-up interval");

   chk_lock_set: assert property (s_lock_write |=> lock_q && !writable_q)
      else $error("lock write did not lock limits");

   chk_start_clear: assert property (s_stop_write |=> !run_q && full_q && !valid_q)
      else $error("start clear did not stop monitoring");

   chk_vbat_hold: assert property (
      vbat_q && !vbat_updated && !standby_power_on_reset |=> vbat_q)
      else $error("battery request dropped without update");

   chk_status_run: assert property (start_q |-> status_q && run_q)
      else $error("status or run missing while started");

   chk_override_lock: assert property (
      s_locked_write ##0 reg_wdata[OVERRIDE_BIT] |=> override_q && full_q)
      else $error("override write ignored while locked");

   chk_read_idle: assert property (!rd_hit |=> rdata_q == READ_IDLE)
      else $error("read data not idle outside a read");

   chk_duty_manual: assert property (start_d && manual_mode |=> !duty_full_q)
      else $error("duty readback full in manual run");

endmodule : monitor_start_lock_control

// ==== tb/monitor_start_lock_control_test.sv ====
`timescale 1ns/100ps

module monitor_start_lock_control_test;
   import monitor_ctrl_pkg::*;

   // ------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------
   logic       clk;
   logic       rst_n;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic       main_power_good;
   logic       standby_power_on_reset;
   logic       vbat_updated;
   logic       manual_mode;
   logic       monitor_run;
   logic       limits_writable;
   logic       pwm_full_duty;
   logic       duty_read_full;
   logic       vbat_request;
   logic       status_set_en;
   logic       readings_valid_flag;
   logic [7:0] outs;
   int         err_total;
   int         checked;

   // Short start-up count keeps the run brief
   monitor_start_lock_control #(.STARTUP_CYCLES(8)) DUT (
      .clk                    (clk),
      .rst_n                  (rst_n),
      .reg_addr               (reg_addr),
      .reg_wdata              (reg_wdata),
      .reg_wr                 (reg_wr),
      .reg_rd                 (reg_rd),
      .reg_rdata              (reg_rdata),
      .main_power_good        (main_power_good),
      .standby_power_on_reset (standby_power_on_reset),
      .vbat_updated           (vbat_updated),
      .manual_mode            (manual_mode),
      .monitor_run            (monitor_run),
      .limits_writable        (limits_writable),
      .pwm_full_duty          (pwm_full_duty),
      .duty_read_full         (duty_read_full),
      .vbat_request           (vbat_request),
      .status_set_en          (status_set_en),
      .readings_valid_flag    (readings_valid_flag)
   );

   // Flags packed so one compare covers every output flag except readings_valid_flag
   assign outs = {2'b00, status_set_en, vbat_request, duty_read_full,
                  pwm_full_duty, limits_writable, monitor_run};

   always #5 clk = ~clk;

   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic settle();
      @(posedge clk);
      #1;
   endtask : settle

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
      settle();
   endtask : wr

   // Read data stand only in the cycle after the strobe edge
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      check(reg_rdata, exp);
   endtask : rd

   // One-cycle pulse on the battery update or on the standby reset
   task automatic pulse(input logic standby);
      @(posedge clk);
      if (standby) begin
         standby_power_on_reset <= 1'b1;
      end else begin
         vbat_updated <= 1'b1;
      end
      @(posedge clk);
      standby_power_on_reset <= 1'b0;
      vbat_updated           <= 1'b0;
      settle();
   endtask : pulse

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : give_verdict

   // ------------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------------
   initial begin
      clk                    = 1'b0;
      rst_n                  = 1'b0;
      reg_addr               = 8'h00;
      reg_wdata              = 8'h00;
      reg_wr                 = 1'b0;
      reg_rd                 = 1'b0;
      main_power_good        = 1'b1;
      standby_power_on_reset = 1'b0;
      vbat_updated           = 1'b0;
      manual_mode            = 1'b1;
      err_total              = 0;
      checked                = 0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      check(outs, 8'h0E);
      rd(CTRL_OFFSET, CTRL_RESET);
      settle();
      check(reg_rdata, READ_IDLE);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= CTRL_OFFSET;
      reg_wdata <= 8'hE1;
      @(posedge clk);
      reg_wr <= 1'b0;
      repeat (7) @(posedge clk);
      #1;
      check(readings_valid_flag, 1'b0);
      settle();
      check(readings_valid_flag, 1'b1);
      check(outs, 8'h23);
      rd(CTRL_OFFSET, 8'h05);
      @(posedge clk) manual_mode <= 1'b0;
      settle();
      check(outs, 8'h2B);
      wr(CTRL_OFFSET, 8'h09);
      check(outs, 8'h2F);
      rd(CTRL_OFFSET, 8'h0D);
      wr(CTRL_OFFSET, 8'h00);
      check(outs, 8'h0E);
      check(readings_valid_flag, 1'b0);
      wr(CTRL_OFFSET, 8'h10);
      check(outs, 8'h1E);
      wr(CTRL_OFFSET, 8'h00);
      rd(CTRL_OFFSET, 8'h14);
      pulse(1'b0);
      check(outs, 8'h0E);
      wr(CTRL_OFFSET, 8'h10);
      pulse(1'b1);
      check(outs, 8'h0E);
      // Fan logic needs one slow fan clock to leave auto mode
      repeat (FAN_SETTLE_CYCLES) @(posedge clk);
      wr(CTRL_OFFSET, 8'h03);
      check(outs, 8'h29);
      wr(CTRL_OFFSET, 8'h00);
      rd(CTRL_OFFSET, 8'h07);
      wr(CTRL_OFFSET, 8'h18);
      rd(CTRL_OFFSET, 8'h1F);
      check(outs, 8'h3D);
      @(posedge clk) main_power_good <= 1'b0;
      @(posedge clk) main_power_good <= 1'b1;
      settle();
      settle();
      check(outs, 8'h3F);
      rd(CTRL_OFFSET, 8'h1D);
      wr(CTRL_OFFSET, 8'h00);
      check(outs, 8'h1E);
      rd(8'h41, READ_IDLE);
      wr(8'h41, 8'h01);
      rd(CTRL_OFFSET, 8'h14);
      give_verdict();
   end

   // Sequence takes about 1330 cycles, most of it the fan pause
   initial begin
      repeat (FAN_SETTLE_CYCLES + 2000) @(posedge clk);
      err_total++;
      give_verdict();
   end

endmodule : monitor_start_lock_control_test
